/* common/dsp_mac_params.svh */
// constants of the multiply-accumulate slice
// What this block does
// - slice reset clears its assigned registers at once, without a clock edge
// - per-operand signed select: low unsigned, high two's-complement, per cycle
// - accumulate/load select: low adds product to or subtracts it from held value, high loads
// - add/subtract select: low subtracts, high adds, per cycle
// - per-operand source select: low parallel input, high shift-chain input only when W is below 18 (else parallel input)
// - each register picks its own clock use, clock enable and reset; the output register can be bypassed only while the MAC enable bit is clear
`ifndef DSP_MAC_PARAMS_SVH
`define DSP_MAC_PARAMS_SVH

`define OP_W_DEF      18
`define ACC_W_DEF     52
`define SHIFT_MAX_W   18
`define NUM_STAGES    10

`define ST_IN_A       0
`define ST_IN_B       1
`define ST_SGN_A      2
`define ST_SGN_B      3
`define ST_ADD_IN     4
`define ST_LOAD_IN    5
`define ST_PIPE       6
`define ST_ADD_PIPE   7
`define ST_LOAD_PIPE  8
`define ST_OUT        9

`define OFF_BYPASS    8'h00
`define OFF_CE_SEL    8'h04
`define OFF_RST_SEL   8'h08
`define OFF_CTRL      8'h0c
`define OFF_ACC_LO    8'h10
`define OFF_ACC_HI    8'h14

`define RST_BYPASS    10'h000
`define RST_CE_SEL    10'h000
`define RST_RST_SEL   10'h000
`define RST_MAC_EN    1'h1
`define CTRL_MAC_BIT  0

`endif

/* common/dsp_mac_pkg.sv */
// types of the multiply-accumulate slice
`include "dsp_mac_params.svh"
package dsp_mac_pkg;
  typedef logic [`NUM_STAGES-1:0] stage_mask_t;
  typedef enum logic [1:0] {
    HTRANS_IDLE   = 2'h0,
    HTRANS_BUSY   = 2'h1,
    HTRANS_NONSEQ = 2'h2,
    HTRANS_SEQ    = 2'h3
  } htrans_e;
endpackage

/* rtl/mac_stage.sv */
// one optional register stage with its own enable and reset
module mac_stage #(
  parameter int W = 1
) (
  // clocking
  input  wire logic         clk,
  input  wire logic         arst,
  input  wire logic         ce,
  input  wire logic         bypass,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    q_next = q_reg;
    if (ce) begin
      q_next = d;
    end
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = bypass ? d : q_reg;

  a_async_clear: assert property (@(posedge clk) arst |-> q_reg == '0)
    else $error("stage not cleared under reset");
  a_ce_hold: assert property (@(posedge clk) disable iff (arst)
    !ce |=> q_reg == $past(q_reg))
    else $error("stage changed with enable low");
  a_ce_take: assert property (@(posedge clk) disable iff (arst)
    ce |=> q_reg == $past(d))
    else $error("stage missed its input");
endmodule

/* rtl/dsp_mac_slice.sv */
// multiply / multiply-accumulate slice with per-register controls
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`include "dsp_mac_params.svh"
module dsp_mac_slice #(
  parameter int W     = `OP_W_DEF,
  parameter int ACC_W = `ACC_W_DEF
) (
  // clock and bus reset
  input  wire logic             clk,
  input  wire logic             rst,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  // slice clock enables and resets
  input  wire logic             slice_ce_0,
  input  wire logic             slice_ce_1,
  input  wire logic             slice_rst_0,
  input  wire logic             slice_rst_1,
  // operands
  input  wire logic [W-1:0]     a_par,
  input  wire logic [W-1:0]     b_par,
  input  wire logic [W-1:0]     a_shift_in,
  input  wire logic [W-1:0]     b_shift_in,
  output logic      [W-1:0]     a_shift_out,
  output logic      [W-1:0]     b_shift_out,
  // dynamic controls
  input  wire logic             operand_a_signed_sel,
  input  wire logic             operand_b_signed_sel,
  input  wire logic             accum_load_sel,
  input  wire logic             add_not_sub_sel,
  input  wire logic             operand_a_shift_src_sel,
  input  wire logic             operand_b_shift_src_sel,
  // result
  output logic      [ACC_W-1:0] result
);
  localparam int PW = 2 * W + 2;
  localparam logic SHIFT_OK = (W < `SHIFT_MAX_W);

  dsp_mac_pkg::stage_mask_t byp_reg, byp_next, ce_sel_reg, ce_sel_next;
  dsp_mac_pkg::stage_mask_t rsel_reg, rsel_next, byp, st_ce, st_arst;
  logic             mac_en_reg, mac_en_next;
  logic             wr_pend_reg, wr_pend_next;
  logic [7:0]       wr_addr_reg, wr_addr_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             take;
  logic [63:0]      acc_wide;
  logic [W-1:0]     a_d, b_d, a_q, b_q;
  logic [5:0]       ctl_d, ctl_q;
  logic [W:0]       a_x, b_x;
  logic [PW-1:0]    prod_raw, prod_q;
  logic [ACC_W-1:0] prod_ext, out_d, out_q;

  // register file
  assign take = hsel && hready && htrans[1];
  assign acc_wide = {{(64 - ACC_W){1'b0}}, result};

  always_comb begin
    byp_next     = byp_reg;
    ce_sel_next  = ce_sel_reg;
    rsel_next    = rsel_reg;
    mac_en_next  = mac_en_reg;
    wr_pend_next = take && hwrite;
    wr_addr_next = take ? haddr[7:0] : wr_addr_reg;
    rdata_next   = rdata_reg;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `OFF_BYPASS:  byp_next    = hwdata[`NUM_STAGES-1:0];
        `OFF_CE_SEL:  ce_sel_next = hwdata[`NUM_STAGES-1:0];
        `OFF_RST_SEL: rsel_next   = hwdata[`NUM_STAGES-1:0];
        `OFF_CTRL:    mac_en_next = hwdata[`CTRL_MAC_BIT];
        default:      mac_en_next = mac_en_reg;
      endcase
    end
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        `OFF_BYPASS:  rdata_next = {22'h000000, byp_next};
        `OFF_CE_SEL:  rdata_next = {22'h000000, ce_sel_next};
        `OFF_RST_SEL: rdata_next = {22'h000000, rsel_next};
        `OFF_CTRL:    rdata_next = {31'h00000000, mac_en_next};
        `OFF_ACC_LO:  rdata_next = acc_wide[31:0];
        `OFF_ACC_HI:  rdata_next = acc_wide[63:32];
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      byp_reg     <= `RST_BYPASS;
      ce_sel_reg  <= `RST_CE_SEL;
      rsel_reg    <= `RST_RST_SEL;
      mac_en_reg  <= `RST_MAC_EN;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= 32'h00000000;
    end else begin
      byp_reg     <= byp_next;
      ce_sel_reg  <= ce_sel_next;
      rsel_reg    <= rsel_next;
      mac_en_reg  <= mac_en_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // per-register enable and reset choice
  for (genvar i = 0; i < `NUM_STAGES; i++) begin : g_sel
    assign st_ce[i]   = ce_sel_reg[i] ? slice_ce_1 : slice_ce_0;
    assign st_arst[i] = rsel_reg[i] ? slice_rst_1 : slice_rst_0;
    if (i == `ST_OUT) begin : g_out
      assign byp[i] = byp_reg[i] && !mac_en_reg;
    end else begin : g_other
      assign byp[i] = byp_reg[i];
    end
  end

  // input stages
  assign a_d = (operand_a_shift_src_sel && SHIFT_OK) ? a_shift_in : a_par;
  assign b_d = (operand_b_shift_src_sel && SHIFT_OK) ? b_shift_in : b_par;

  mac_stage #(.W(W)) u_in_a (
    .clk(clk), .arst(st_arst[`ST_IN_A]), .ce(st_ce[`ST_IN_A]),
    .bypass(byp[`ST_IN_A]), .d(a_d), .q(a_q)
  );
  mac_stage #(.W(W)) u_in_b (
    .clk(clk), .arst(st_arst[`ST_IN_B]), .ce(st_ce[`ST_IN_B]),
    .bypass(byp[`ST_IN_B]), .d(b_d), .q(b_q)
  );
  assign a_shift_out = a_q;
  assign b_shift_out = b_q;

  // control select stages, kept in step with the data
  assign ctl_d = {ctl_q[3], ctl_q[2], accum_load_sel, add_not_sub_sel,
                  operand_b_signed_sel, operand_a_signed_sel};
  for (genvar k = 0; k < 6; k++) begin : g_ctl
    localparam int S = (k < 4) ? (k + 2) : (k + 3);
    mac_stage #(.W(1)) u_ctl (
      .clk(clk), .arst(st_arst[S]), .ce(st_ce[S]),
      .bypass(byp[S]), .d(ctl_d[k]), .q(ctl_q[k])
    );
  end

  // multiplier and pipeline
  assign a_x = {ctl_q[0] & a_q[W-1], a_q};
  assign b_x = {ctl_q[1] & b_q[W-1], b_q};
  assign prod_raw = $signed(a_x) * $signed(b_x);

  mac_stage #(.W(PW)) u_pipe (
    .clk(clk), .arst(st_arst[`ST_PIPE]), .ce(st_ce[`ST_PIPE]),
    .bypass(byp[`ST_PIPE]), .d(prod_raw), .q(prod_q)
  );

  // accumulator
  assign prod_ext = {{(ACC_W - PW){prod_q[PW-1]}}, prod_q};
  always_comb begin
    if (!mac_en_reg || ctl_q[5]) begin
      out_d = prod_ext;
    end else if (ctl_q[4]) begin
      out_d = out_q + prod_ext;
    end else begin
      out_d = out_q - prod_ext;
    end
  end

  mac_stage #(.W(ACC_W)) u_out (
    .clk(clk), .arst(st_arst[`ST_OUT]), .ce(st_ce[`ST_OUT]),
    .bypass(1'b0), .d(out_d), .q(out_q)
  );
  // bypass taken here so the accumulator feedback never loops back
  assign result = byp[`ST_OUT] ? out_d : out_q;

  // checks
  logic acc_go;
  assign acc_go = mac_en_reg && st_ce[`ST_OUT] && !st_arst[`ST_OUT];

  a_acc_load: assert property (@(posedge clk) disable iff (rst)
    acc_go && ctl_q[5] ##1 !st_arst[`ST_OUT] |-> result == $past(prod_ext))
    else $error("load did not replace accumulator");
  a_acc_add: assert property (@(posedge clk) disable iff (rst)
    acc_go && !ctl_q[5] && ctl_q[4] ##1 !st_arst[`ST_OUT]
    |-> result == $past(out_q) + $past(prod_ext))
    else $error("accumulate add wrong");
  a_acc_sub: assert property (@(posedge clk) disable iff (rst)
    acc_go && !ctl_q[5] && !ctl_q[4] ##1 !st_arst[`ST_OUT]
    |-> result == $past(out_q) - $past(prod_ext))
    else $error("accumulate subtract wrong");
  a_mul_unsigned: assert property (@(posedge clk) disable iff (rst)
    !ctl_q[0] && !ctl_q[1] |-> prod_raw == PW'(a_q) * PW'(b_q))
    else $error("unsigned product wrong");
  a_mul_signed: assert property (@(posedge clk) disable iff (rst)
    ctl_q[0] && ctl_q[1]
    |-> $signed(prod_raw) == $signed(a_q) * $signed(b_q))
    else $error("signed product wrong");
  a_src_par: assert property (@(posedge clk) disable iff (rst)
    !operand_a_shift_src_sel && st_ce[`ST_IN_A] && !byp[`ST_IN_A]
    && !st_arst[`ST_IN_A] ##1 !st_arst[`ST_IN_A]
    |-> a_q == $past(a_par))
    else $error("parallel source not taken");
  a_src_shift: assert property (@(posedge clk) disable iff (rst)
    SHIFT_OK && operand_a_shift_src_sel && st_ce[`ST_IN_A]
    && !byp[`ST_IN_A] && !st_arst[`ST_IN_A] ##1 !st_arst[`ST_IN_A]
    |-> a_q == $past(a_shift_in))
    else $error("shift source not taken");
  a_out_reset: assert property (@(posedge clk)
    st_arst[`ST_OUT] && !byp[`ST_OUT] |-> result == '0)
    else $error("result not cleared by its reset");

  c_load_then_add: cover property (@(posedge clk) disable iff (rst)
    acc_go && ctl_q[5] ##1 acc_go && !ctl_q[5] && ctl_q[4]);
  c_subtract: cover property (@(posedge clk) disable iff (rst)
    acc_go && !ctl_q[5] && !ctl_q[4]);
  c_signed_mul: cover property (@(posedge clk) disable iff (rst)
    ctl_q[0] && ctl_q[1] && a_q[W-1] && b_q[W-1]);
endmodule

/* tb/fabric_model.sv */
// user fabric model driving operands and dynamic selects
module fabric_model #(
  parameter int W = 8
) (
  // operands
  output logic [W-1:0] a_par,
  output logic [W-1:0] b_par,
  output logic [W-1:0] a_shift_in,
  output logic [W-1:0] b_shift_in,
  // dynamic selects
  output logic         operand_a_signed_sel,
  output logic         operand_b_signed_sel,
  output logic         accum_load_sel,
  output logic         add_not_sub_sel,
  output logic         operand_a_shift_src_sel,
  output logic         operand_b_shift_src_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {a_par, b_par, a_shift_in, b_shift_in} = '0;
    {operand_a_signed_sel, operand_b_signed_sel} = 2'h0;
    {accum_load_sel, add_not_sub_sel} = 2'h0;
    {operand_a_shift_src_sel, operand_b_shift_src_sel} = 2'h0;
  end
  // c = signed a, signed b, load, add, shift a, shift b
  // the unselected source carries the inverse so a wrong pick shows
  task automatic put(input logic [W-1:0] a, input logic [W-1:0] b,
                     input logic [5:0] c);
    logic xa;
    logic xb;
    xa = c[1] && (W < 18);
    xb = c[0] && (W < 18);
    a_par <= xa ? ~a : a;
    a_shift_in <= xa ? a : ~a;
    b_par <= xb ? ~b : b;
    b_shift_in <= xb ? b : ~b;
    operand_a_shift_src_sel <= xa;
    operand_b_shift_src_sel <= xb;
    operand_a_signed_sel <= c[5];
    operand_b_signed_sel <= c[4];
    accum_load_sel <= c[3];
    add_not_sub_sel <= c[2];
  endtask
endmodule

/* tb/dsp_mac_dynamic_controls_tb_top.sv */
// self-checking bench of the multiply-accumulate slice
module dsp_mac_dynamic_controls_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W  = 8;
  localparam int AW = 52;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [5:0]  c;
    logic [11:0] e;
  } op_row_s;
  logic          clk, rst, hsel, hwrite, ce0, ce1, r0, r1;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic          hreadyout, hresp;
  wire           hready = hreadyout;
  logic [W-1:0]  ap, bp, ai, bi;
  logic          sa, sb, ld, ad, xa, xb;
  logic [AW-1:0] result;
  logic [W-1:0]  aso, bso;
  int            failures, n_checks, cyc;
  op_row_s       rows [8];
  logic [31:0]   ra [6] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h14,
                            32'h20};
  logic [31:0]   re [6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};

  fabric_model #(.W(W)) fab_u (
    .a_par(ap), .b_par(bp), .a_shift_in(ai), .b_shift_in(bi),
    .operand_a_signed_sel(sa), .operand_b_signed_sel(sb),
    .accum_load_sel(ld), .add_not_sub_sel(ad),
    .operand_a_shift_src_sel(xa), .operand_b_shift_src_sel(xb));

  dsp_mac_slice #(.W(W), .ACC_W(AW)) dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .slice_ce_0(ce0), .slice_ce_1(ce1), .slice_rst_0(r0),
    .slice_rst_1(r1), .a_par(ap), .b_par(bp), .a_shift_in(ai),
    .b_shift_in(bi), .a_shift_out(aso), .b_shift_out(bso),
    .operand_a_signed_sel(sa), .operand_b_signed_sel(sb),
    .accum_load_sel(ld), .add_not_sub_sel(ad),
    .operand_a_shift_src_sel(xa), .operand_b_shift_src_sel(xb),
    .result(result));

  always #5 clk = ~clk;

  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      close_out;
    end
  end

  task automatic chk_r(input string nm, input logic [AW-1:0] ex);
    n_checks++;
    if (result !== ex) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, ex, result);
    end
  endtask

  task automatic chk_w(input string nm, input logic [31:0] ex);
    n_checks++;
    if (rd !== ex) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, ex, rd);
    end
  endtask

  task automatic chk_s(input string nm, input logic [2*W-1:0] ex);
    n_checks++;
    if ({aso, bso} !== ex) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, ex, {aso, bso});
    end
  endtask

  task automatic chk_e(input string nm, input logic ex);
    n_checks++;
    if (hresp !== ex) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, ex, hresp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= dsp_mac_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= dsp_mac_pkg::HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_e("okay response", 1'b0);
  endtask

  initial begin
    rows = '{'{8'h03, 8'h04, 6'b001100, 12'h00c},
             '{8'hff, 8'h02, 6'b100100, 12'h00a},
             '{8'hff, 8'h02, 6'b000100, 12'h208},
             '{8'h02, 8'hfe, 6'b010000, 12'h20c},
             '{8'h05, 8'h03, 6'b000000, 12'h1fd},
             '{8'h07, 8'h02, 6'b000110, 12'h20b},
             '{8'h04, 8'h03, 6'b001001, 12'h00c},
             '{8'hff, 8'hff, 6'b110100, 12'h00d}};
    {clk, hsel, hwrite, ce1, failures, n_checks, cyc} = '0;
    {rst, ce0, r0, r1} = 4'hc;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    #1 {r0, r1} = 2'h3;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    r0 <= 1'b0;
    r1 <= 1'b0;
    #1 chk_r("reset result", '0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk_w("reg reset", re[i]);
    end
    bus(1'b1, 32'h20, 32'hffffffff);
    bus(1'b0, 32'h20, 32'h0);
    chk_w("unmapped", 32'h0);
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      if (i < 8)
        fab_u.put(rows[i].a, rows[i].b, rows[i].c);
      else
        fab_u.put(8'h00, 8'h00, 6'b000100);
      #1;
      if (i >= 3)
        chk_r("mac row", AW'(rows[i-3].e));
      if (i >= 1 && i <= 8)
        chk_s("shift out", {rows[i-1].a, rows[i-1].b});
    end
    bus(1'b0, 32'h10, 32'h0);
    chk_w("acc low", 32'hd);
    bus(1'b1, 32'h04, 32'h200);
    fab_u.put(8'h01, 8'h01, 6'b001000);
    repeat (4) @(posedge clk);
    #1 chk_r("output held", AW'(13));
    @(posedge clk) ce1 <= 1'b1;
    @(posedge clk);
    #1 chk_r("output enabled", AW'(1));
    chk_s("shift out held", 16'h0101);
    bus(1'b1, 32'h08, 32'h200);
    @(posedge clk) r0 <= 1'b1;
    #1 chk_r("other reset", AW'(1));
    chk_s("shift out cleared", 16'h0000);
    @(posedge clk) begin
      r0 <= 1'b0;
      r1 <= 1'b1;
    end
    #1 chk_r("async clear", '0);
    @(posedge clk) r1 <= 1'b0;
    bus(1'b1, 32'h0c, 32'h0);
    bus(1'b1, 32'h00, 32'h3ff);
    bus(1'b0, 32'h00, 32'h0);
    chk_w("bypass readback", 32'h3ff);
    @(posedge clk) fab_u.put(8'h03, 8'h05, 6'b000100);
    #1 chk_r("bypassed product", AW'(15));
    close_out;
  end
endmodule
